//--- csps_consts.vh
`ifndef CSPS_CONSTS_VH
`define CSPS_CONSTS_VH

// Register indices on the plain register port
`define CSPS_ADDR_W          3
`define CSPS_A_PLL           3'h0
`define CSPS_A_MCU           3'h1
`define CSPS_A_CMD           3'h2
`define CSPS_A_SEL           3'h3
`define CSPS_A_SLP           3'h4

// pll_control_status fields
`define CSPS_PLL_FACT_HI     5
`define CSPS_PLL_FACT_LO     2
`define CSPS_PLL_EN_BIT      1
`define CSPS_PLL_LOCK_BIT    0
`define CSPS_PLL_FACT_RST    4'h1
`define CSPS_PLL_FACT_MIN    4'h2
`define CSPS_PLL_FACT_MAX    4'h6
`define CSPS_PLL_FACT_OFS    4'h2

// mcu_control fields
`define CSPS_RC_SEL_BIT      2

// clock_command_status fields and command codes
`define CSPS_CCE_BIT         7
`define CSPS_RDY_BIT         4
`define CSPS_CCE_ONLY        8'h80
`define CSPS_CCE_WIN         2'h3
`define CSPS_CMD_NONE        4'h0
`define CSPS_CMD_DISABLE     4'h1
`define CSPS_CMD_ENABLE      4'h2
`define CSPS_CMD_AVAIL       4'h3
`define CSPS_CMD_SWITCH      4'h4
`define CSPS_CMD_RECOVER     4'h5
`define CSPS_CMD_CLOCK_OUTPUT_FUSE       4'h7

// clock_source_selection fields
`define CSPS_CLOCK_OUT_SELECT_BIT        6

// sleep_mode_control fields and modes
`define CSPS_SE_BIT          0
`define CSPS_SM_HI           3
`define CSPS_SM_LO           1
`define CSPS_SM_IDLE         3'h0
`define CSPS_SM_ADCNR        3'h1
`define CSPS_SM_PDOWN        3'h2
`define CSPS_SM_STBY         3'h6

// Wake timing in cycles
`define CSPS_WAKE_EXTRA      8'h04
`define CSPS_STBY_WAKE       8'h06
`define CSPS_SUT0_CYC        8'h08
`define CSPS_SUT1_CYC        8'h10
`define CSPS_SUT2_CYC        8'h20
`define CSPS_SUT3_CYC        8'h40

`endif

//--- csps_clock_ctrl.v
`timescale 1ns/100ps
`default_nettype none
`include "csps_consts.vh"
// What this block does
// - PLL factor field codes 2..6 give multipliers 4..8; others reserved.
// - PLL enable starts PLL and also starts the RC oscillator as reference.
// - PLL enable reads and stays one while PLL drives system clock.
// - Lock flag is read-only and shows the PLL locked state.
// - RC select zero means 8 MHz, one means 1 MHz.
// - RC select writes take effect only while RC oscillator is enabled.
// - RC select is cleared by hardware while RC oscillator is disabled.
// - Change enable updates only on a write of it alone.
// - Change enable clears four cycles later or on command write, no restart.
// - Command codes 0..5 and 7 decoded; 1xxx and others mean no command.
// - Ready flag clears on availability request, sets when clock confirmed.
// - Clock-out bit resets from fuse, used by clock-output command only.
// - Start-up code resets from fuse, used by enable and disable commands.
// - Source code resets from fuse; recover loads current system source.
// - Sleep entered only with sleep enable set and sleep instruction.
// - Mode 000 idle, 001 ADC noise, 010 power-down, 110 standby with crystal.
// - Each sleep mode gates its own set of clock domains.
// - Interrupt wake halts four cycles beyond start-up, then runs handler.
// - Reset during sleep restarts from the reset vector.
// - Standby wakes in six cycles since the oscillator keeps running.
module csps_clock_ctrl
(
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Register port
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Fuse values
  input  wire       clock_output_fuse,
  input  wire [1:0] startup_fuses,
  input  wire [3:0] source_fuses,
  // Oscillator and PLL status
  input  wire       pll_lock_in,
  input  wire       pll_is_sys_clk,
  input  wire       rc_osc_enabled,
  input  wire       ext_xtal_selected,
  input  wire [3:0] sys_source_code,
  input  wire       clk_avail_in,
  // PLL and RC oscillator control
  output wire       pll_run,
  output wire       rc_osc_start,
  output reg  [3:0] pll_mult,
  output wire       rc_1mhz_sel,
  // Clock switch engine command
  output reg        cmd_valid,
  output reg  [3:0] cmd_code,
  output reg  [3:0] cmd_source,
  output reg  [1:0] cmd_startup,
  output reg        clock_out_en,
  // Sleep control
  input  wire       sleep_instr,
  input  wire       wake_irq,
  output reg        cpu_clk_en,
  output reg        flash_clk_en,
  output reg        io_clk_en,
  output reg        adc_clk_en,
  output reg        pll_clk_en,
  output reg        main_src_en,
  output reg        irq_resume
);
  localparam ST_RUN   = 2'h0;
  localparam ST_SLEEP = 2'h1;
  localparam ST_WAKE  = 2'h2;
  reg  [3:0] pll_factor_r;
  reg        pll_enable_bit_r;
  reg        rc_freq_select_r;
  reg        cmd_change_enable_r;
  reg  [1:0] cce_cnt_r;
  reg  [3:0] clock_command_code_r;
  reg        clock_ready_flag_r;
  reg        avail_pend_r;
  reg        clock_out_select_r;
  reg  [1:0] startup_code_r;
  reg  [3:0] source_code_r;
  reg        sleep_enable_bit_r;
  reg  [2:0] sleep_mode_field_r;
  reg        fuse_loaded_r;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [2:0] act_mode_r;
  reg  [7:0] wake_cnt_r;
  reg  [7:0] wake_cnt_nxt;
  reg  [7:0] rd_nxt;
  wire       wr_pll = reg_wr && (reg_addr == `CSPS_A_PLL);
  wire       wr_mcu = reg_wr && (reg_addr == `CSPS_A_MCU);
  wire       wr_cmd = reg_wr && (reg_addr == `CSPS_A_CMD);
  wire       wr_sel = reg_wr && (reg_addr == `CSPS_A_SEL);
  wire       wr_slp = reg_wr && (reg_addr == `CSPS_A_SLP);
  // Start-up code to wake cycles, shared by wake timing
  function [7:0] sut_cycles;
    input [1:0] code;
    begin
      case (code)
        2'h0:    sut_cycles = `CSPS_SUT0_CYC;
        2'h1:    sut_cycles = `CSPS_SUT1_CYC;
        2'h2:    sut_cycles = `CSPS_SUT2_CYC;
        default: sut_cycles = `CSPS_SUT3_CYC;
      endcase
    end
  endfunction
  wire       pll_en_eff = pll_enable_bit_r | pll_is_sys_clk;
  assign pll_run      = pll_en_eff;
  assign rc_osc_start = pll_en_eff;
  assign rc_1mhz_sel  = rc_freq_select_r;
  always @*
  begin
    if (pll_factor_r >= `CSPS_PLL_FACT_MIN && pll_factor_r <= `CSPS_PLL_FACT_MAX)
      pll_mult = pll_factor_r + `CSPS_PLL_FACT_OFS;
    else
      pll_mult = 4'h0;
  end
  // PLL and MCU control registers
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pll_factor_r     <= `CSPS_PLL_FACT_RST;
      pll_enable_bit_r <= 1'b0;
      rc_freq_select_r <= 1'b0;
    end
    else
    begin
      if (pll_is_sys_clk)
        pll_enable_bit_r <= 1'b1;
      else if (wr_pll)
        pll_enable_bit_r <= reg_wdata[`CSPS_PLL_EN_BIT];
      if (wr_pll)
        pll_factor_r <= reg_wdata[`CSPS_PLL_FACT_HI:`CSPS_PLL_FACT_LO];
      if (!rc_osc_enabled)
        rc_freq_select_r <= 1'b0;
      else if (wr_mcu)
        rc_freq_select_r <= reg_wdata[`CSPS_RC_SEL_BIT];
    end
  end
  wire       cmd_take = wr_cmd && cmd_change_enable_r && !reg_wdata[`CSPS_CCE_BIT];
  wire [3:0] cmd_eff  = reg_wdata[3] ? `CSPS_CMD_NONE : reg_wdata[3:0];
  // Change enable and command register
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_change_enable_r  <= 1'b0;
      cce_cnt_r            <= 2'h0;
      clock_command_code_r <= 4'h0;
    end
    else
    begin
      if (wr_cmd && reg_wdata == `CSPS_CCE_ONLY && !cmd_change_enable_r)
      begin
        cmd_change_enable_r <= 1'b1;
        cce_cnt_r           <= `CSPS_CCE_WIN;
      end
      else if (cmd_take || (cmd_change_enable_r && cce_cnt_r == 2'h0))
        cmd_change_enable_r <= 1'b0;
      else if (cmd_change_enable_r)
        cce_cnt_r <= cce_cnt_r - 2'h1;
      if (cmd_take)
        clock_command_code_r <= reg_wdata[3:0];
    end
  end
  // Command issue to the switch engine
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd_valid    <= 1'b0;
      cmd_code     <= 4'h0;
      cmd_source   <= 4'h0;
      cmd_startup  <= 2'h0;
      clock_out_en <= 1'b0;
    end
    else
    begin
      cmd_valid <= 1'b0;
      if (cmd_take && cmd_eff != `CSPS_CMD_NONE && cmd_eff != 4'h6)
      begin
        cmd_valid   <= 1'b1;
        cmd_code    <= cmd_eff;
        cmd_source  <= source_code_r;
        cmd_startup <= startup_code_r;
      end
      if (cmd_take && cmd_eff == `CSPS_CMD_CLOCK_OUTPUT_FUSE)
        clock_out_en <= clock_out_select_r;
    end
  end
  // Selection register, fuse load after reset release
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fuse_loaded_r      <= 1'b0;
      clock_out_select_r <= 1'b0;
      startup_code_r     <= 2'h0;
      source_code_r      <= 4'h0;
    end
    else
    begin
      fuse_loaded_r <= 1'b1;
      if (!fuse_loaded_r)
      begin
        clock_out_select_r <= clock_output_fuse;
        startup_code_r     <= startup_fuses;
        source_code_r      <= source_fuses;
      end
      else if (cmd_take && cmd_eff == `CSPS_CMD_RECOVER)
        source_code_r <= sys_source_code;
      else if (wr_sel)
      begin
        clock_out_select_r <= reg_wdata[`CSPS_CLOCK_OUT_SELECT_BIT];
        startup_code_r     <= reg_wdata[5:4];
        source_code_r      <= reg_wdata[3:0];
      end
    end
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clock_ready_flag_r <= 1'b0;
      avail_pend_r       <= 1'b0;
    end
    else if (cmd_take && cmd_eff == `CSPS_CMD_AVAIL)
    begin
      clock_ready_flag_r <= 1'b0;
      avail_pend_r       <= 1'b1;
    end
    else if (avail_pend_r && clk_avail_in)
    begin
      clock_ready_flag_r <= 1'b1;
      avail_pend_r       <= 1'b0;
    end
  end
  // Sleep control register
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_enable_bit_r <= 1'b0;
      sleep_mode_field_r <= 3'h0;
    end
    else if (wr_slp)
    begin
      sleep_enable_bit_r <= reg_wdata[`CSPS_SE_BIT];
      sleep_mode_field_r <= reg_wdata[`CSPS_SM_HI:`CSPS_SM_LO];
    end
  end
  wire       mode_ok = (sleep_mode_field_r == `CSPS_SM_IDLE) ||
                   (sleep_mode_field_r == `CSPS_SM_ADCNR) ||
                   (sleep_mode_field_r == `CSPS_SM_PDOWN) ||
                   (sleep_mode_field_r == `CSPS_SM_STBY && ext_xtal_selected);
  // Sleep state machine; reset simply returns to run, so the CPU restarts
  always @*
  begin
    state_nxt    = state_r;
    wake_cnt_nxt = wake_cnt_r;
    case (state_r)
      ST_RUN:
        if (sleep_instr && sleep_enable_bit_r && mode_ok)
          state_nxt = ST_SLEEP;
      ST_SLEEP:
        if (wake_irq)
        begin
          state_nxt = ST_WAKE;
          if (act_mode_r == `CSPS_SM_STBY)
            wake_cnt_nxt = `CSPS_STBY_WAKE - 8'h1;
          else if (act_mode_r == `CSPS_SM_PDOWN)
            wake_cnt_nxt = sut_cycles(startup_code_r) + `CSPS_WAKE_EXTRA - 8'h1;
          else
            wake_cnt_nxt = `CSPS_WAKE_EXTRA - 8'h1;
        end
      ST_WAKE:
        if (wake_cnt_r == 8'h0)
          state_nxt = ST_RUN;
        else
          wake_cnt_nxt = wake_cnt_r - 8'h1;
      default:
        state_nxt = ST_RUN;
    endcase
  end
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= ST_RUN;
      act_mode_r <= 3'h0;
      wake_cnt_r <= 8'h0;
      irq_resume <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      wake_cnt_r <= wake_cnt_nxt;
      irq_resume <= (state_r == ST_WAKE) && (state_nxt == ST_RUN);
      if (state_r == ST_RUN)
        act_mode_r <= sleep_mode_field_r;
    end
  end
  always @*
  begin
    cpu_clk_en   = 1'b1;
    flash_clk_en = 1'b1;
    io_clk_en    = 1'b1;
    adc_clk_en   = 1'b1;
    pll_clk_en   = 1'b1;
    main_src_en  = 1'b1;
    if (state_r != ST_RUN)
    begin
      cpu_clk_en   = 1'b0;
      flash_clk_en = 1'b0;
    end
    if (state_r == ST_SLEEP)
    begin
      case (act_mode_r)
        `CSPS_SM_IDLE:
          io_clk_en = 1'b1;
        `CSPS_SM_ADCNR:
          io_clk_en = 1'b0;
        `CSPS_SM_STBY:
        begin
          io_clk_en  = 1'b0;
          adc_clk_en = 1'b0;
          pll_clk_en = 1'b0;
        end
        default:
        begin
          io_clk_en   = 1'b0;
          adc_clk_en  = 1'b0;
          pll_clk_en  = 1'b0;
          main_src_en = 1'b0;
        end
      endcase
    end
  end
  // Read mux; reserved bits read zero
  always @*
  begin
    rd_nxt = 8'h00;
    case (reg_addr)
      `CSPS_A_PLL:
        rd_nxt = {2'h0, pll_factor_r, pll_en_eff, pll_lock_in};
      `CSPS_A_MCU:
        rd_nxt = {5'h00, rc_freq_select_r, 2'h0};
      `CSPS_A_CMD:
        rd_nxt = {cmd_change_enable_r, 2'h0, clock_ready_flag_r, clock_command_code_r};
      `CSPS_A_SEL:
        rd_nxt = {1'b0, clock_out_select_r, startup_code_r, source_code_r};
      `CSPS_A_SLP:
        rd_nxt = {4'h0, sleep_mode_field_r, sleep_enable_bit_r};
      default:
        rd_nxt = 8'h00;
    endcase
  end
  // Read data valid only in the cycle after the strobe
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? rd_nxt : 8'h00;
  end
endmodule // csps_clock_ctrl
`default_nettype wire

//--- csps_clock_ctrl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "csps_consts.vh"
module csps_clock_ctrl_asserts
(
  // Clock, reset and register port
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  // Status inputs
  input wire logic       pll_is_sys_clk,
  input wire logic       rc_osc_enabled,
  input wire logic       sleep_instr,
  input wire logic       wake_irq,
  // Observed outputs
  input wire logic       pll_run,
  input wire logic       rc_osc_start,
  input wire logic [3:0] pll_mult,
  input wire logic       rc_1mhz_sel,
  input wire logic       cmd_valid,
  input wire logic [3:0] cmd_code,
  input wire logic       clock_out_en,
  input wire logic       cpu_clk_en,
  input wire logic       flash_clk_en,
  input wire logic       io_clk_en,
  input wire logic       adc_clk_en,
  input wire logic       pll_clk_en,
  input wire logic       main_src_en,
  input wire logic       irq_resume
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_pll_forced: assert property (pll_is_sys_clk |-> pll_run)
    else $error("PLL not forced on");
  chk_ref_start: assert property (rc_osc_start == pll_run)
    else $error("RC reference not started with PLL");
  chk_mult_map: assert property (reg_wr && reg_addr == `CSPS_A_PLL |=> pll_mult ==
    ($past(reg_wdata[5:2]) inside {[4'h2:4'h6]} ? $past(reg_wdata[5:2]) + 4'h2 : 4'h0))
    else $error("PLL multiplier wrong");
  chk_rc_clear: assert property (!rc_osc_enabled ##1 !rc_osc_enabled |-> !rc_1mhz_sel)
    else $error("RC select not cleared");
  chk_rc_write: assert property ($rose(rc_1mhz_sel) |-> $past(reg_wr && rc_osc_enabled
    && reg_addr == `CSPS_A_MCU && reg_wdata[`CSPS_RC_SEL_BIT]))
    else $error("RC select set without legal write");
  chk_cmd_source: assert property (cmd_valid |->
    $past(reg_wr && reg_addr == `CSPS_A_CMD && !reg_wdata[`CSPS_CCE_BIT]) ##1 !cmd_valid)
    else $error("Command pulse without command write");
  chk_cmd_codes: assert property (cmd_valid |-> !cmd_code[3] && cmd_code != 4'h0
    && cmd_code != 4'h6)
    else $error("Command issued for a no-command code");
  chk_clock_out_select_cmd: assert property ($changed(clock_out_en) |->
    cmd_valid && cmd_code == `CSPS_CMD_CLOCK_OUTPUT_FUSE)
    else $error("Clock out changed without its command");
  chk_sleep_entry: assert property ($fell(cpu_clk_en) |-> $past(sleep_instr))
    else $error("CPU clock stopped without sleep");
  chk_domain_set: assert property (cpu_clk_en == flash_clk_en && (io_clk_en || !cpu_clk_en)
    && (main_src_en || !(io_clk_en || adc_clk_en || pll_clk_en)))
    else $error("Clock gating set inconsistent");
  chk_resume_pulse: assert property (irq_resume |-> cpu_clk_en && !$past(cpu_clk_en)
    ##1 !irq_resume)
    else $error("Resume pulse misplaced");
  chk_idle_wake: assert property (!cpu_clk_en && io_clk_en && wake_irq |->
    ##[4:6] irq_resume)
    else $error("Idle wake time wrong");
  chk_stby_wake: assert property (!cpu_clk_en && !io_clk_en && !adc_clk_en && main_src_en
    && wake_irq |-> ##[6:8] irq_resume)
    else $error("Standby wake time wrong");
  chk_reset_run: assert property ($rose(rst_n) |-> cpu_clk_en && main_src_en)
    else $error("Not running after reset");

  cover property (cmd_valid && cmd_code == `CSPS_CMD_RECOVER);
  cover property (irq_resume);
  cover property ($rose(rc_1mhz_sel));
endmodule // csps_clock_ctrl_asserts

bind csps_clock_ctrl csps_clock_ctrl_asserts csps_clock_ctrl_asserts_i (.clk(clk),
  .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .pll_is_sys_clk(pll_is_sys_clk), .rc_osc_enabled(rc_osc_enabled),
  .sleep_instr(sleep_instr), .wake_irq(wake_irq), .pll_run(pll_run),
  .rc_osc_start(rc_osc_start), .pll_mult(pll_mult), .rc_1mhz_sel(rc_1mhz_sel),
  .cmd_valid(cmd_valid), .cmd_code(cmd_code), .clock_out_en(clock_out_en),
  .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en), .io_clk_en(io_clk_en),
  .adc_clk_en(adc_clk_en), .pll_clk_en(pll_clk_en), .main_src_en(main_src_en),
  .irq_resume(irq_resume));
`default_nettype wire

//--- tb_csps_clock_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "csps_consts.vh"
module tb_csps_clock_ctrl;
  typedef struct packed {logic [7:0] d; logic [7:0] r; logic [3:0] m; logic e;} csps_row_t;
  logic       clk, rst_n, reg_wr, reg_rd, clock_output_fuse, pll_lock_in, pll_is_sys_clk;
  logic       rc_osc_enabled, ext_xtal_selected, clk_avail_in, sleep_instr, wake_irq;
  logic       pll_run, rc_osc_start, rc_1mhz_sel, cmd_valid, clock_out_en, irq_resume;
  logic       cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, pll_clk_en, main_src_en;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [1:0] startup_fuses, cmd_startup;
  logic [3:0] source_fuses, sys_source_code, pll_mult, cmd_code, cmd_source;
  int         fails, num_checks, n;
  logic [3:0] good[5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
  logic [3:0] none[4] = '{4'h0, 4'h6, 4'h8, 4'hf};
  csps_row_t  rows[10] = '{'{8'h00, 8'h00, 4'h0, 1'b0}, '{8'h04, 8'h04, 4'h0, 1'b0},
    '{8'h08, 8'h08, 4'h4, 1'b0}, '{8'h0c, 8'h0c, 4'h5, 1'b0}, '{8'h10, 8'h10, 4'h6, 1'b0},
    '{8'h14, 8'h14, 4'h7, 1'b0}, '{8'h18, 8'h18, 4'h8, 1'b0}, '{8'h1c, 8'h1c, 4'h0, 1'b0},
    '{8'hff, 8'h3e, 4'h0, 1'b1}, '{8'h1a, 8'h1a, 4'h8, 1'b1}};

  csps_clock_ctrl csps_clock_ctrl_i (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .clock_output_fuse(clock_output_fuse), .startup_fuses(startup_fuses),
    .source_fuses(source_fuses), .pll_lock_in(pll_lock_in), .pll_is_sys_clk(pll_is_sys_clk),
    .rc_osc_enabled(rc_osc_enabled), .ext_xtal_selected(ext_xtal_selected),
    .sys_source_code(sys_source_code), .clk_avail_in(clk_avail_in), .pll_run(pll_run),
    .rc_osc_start(rc_osc_start), .pll_mult(pll_mult), .rc_1mhz_sel(rc_1mhz_sel),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_source(cmd_source),
    .cmd_startup(cmd_startup), .clock_out_en(clock_out_en), .sleep_instr(sleep_instr),
    .wake_irq(wake_irq), .cpu_clk_en(cpu_clk_en), .flash_clk_en(flash_clk_en),
    .io_clk_en(io_clk_en), .adc_clk_en(adc_clk_en), .pll_clk_en(pll_clk_en),
    .main_src_en(main_src_en), .irq_resume(irq_resume));

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // The write strobe stays up until idle or the next access lowers it; rd lowers its own strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask

  task automatic idle(input int c);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (c) @(posedge clk);
  endtask

  task automatic rd(input logic [2:0] a);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask

  task automatic issue(input logic [7:0] first, input int g1, input int g2,
    input logic [3:0] c, input logic ev);
    wr(`CSPS_A_CMD, first);
    // Zero gap keeps the strobe up, never lowered and raised at once
    if (g1 > 0)
      idle(g1);
    if (g2 >= 0)
    begin
      wr(`CSPS_A_CMD, `CSPS_CCE_ONLY);
      if (g2 > 0)
        idle(g2);
    end
    wr(`CSPS_A_CMD, {4'h0, c});
    idle(0);
    #1 chk(cmd_valid, ev, "cmd_valid");
  endtask

  task automatic nap(input logic [3:0] sm, input logic [5:0] en);
    wr(`CSPS_A_SLP, {4'h0, sm});
    sleep_instr <= 1'b1;
    idle(1);
    sleep_instr <= 1'b0;
    #1 chk({cpu_clk_en, flash_clk_en, io_clk_en, adc_clk_en, pll_clk_en, main_src_en}, en,
      "gating");
  endtask

  // Counts edges from the one that samples the interrupt
  task automatic wake(input int w);
    wake_irq <= 1'b1;
    @(posedge clk);
    wake_irq <= 1'b0;
    n = 1;
    #1;
    while (irq_resume !== 1'b1 && n < 200)
    begin
      @(posedge clk);
      n++;
      #1;
    end
    chk(n[7:0], 8'(w + 1), "wake cycles");
    chk(cpu_clk_en, 1'b1, "resumed");
    if (n >= 200)
      results();
  endtask

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, pll_lock_in, pll_is_sys_clk} = '0;
    {sleep_instr, wake_irq, clk_avail_in, rst_n} = '0;
    {clock_output_fuse, startup_fuses, source_fuses} = 7'h69;
    {rc_osc_enabled, ext_xtal_selected, sys_source_code} = 6'h33;
    fails = 0;
    num_checks = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    idle(2);
    rd(`CSPS_A_SEL);
    chk(rv, 8'h69, "fuse load");
    rd(`CSPS_A_PLL);
    chk(rv, 8'h04, "pll reset");
    rd(`CSPS_A_CMD);
    chk(rv, 8'h00, "cmd reset");
    wr(3'h5, 8'hff);
    rd(3'h5);
    chk(rv, 8'h00, "unmapped");
    foreach (rows[i])
    begin
      wr(`CSPS_A_PLL, rows[i].d);
      rd(`CSPS_A_PLL);
      chk(rv, rows[i].r, "pll reg");
      chk(pll_mult, rows[i].m, "mult");
      chk(pll_run, rows[i].e, "pll run");
      chk(rc_osc_start, rows[i].e, "rc start");
    end
    $display("table done");
    pll_is_sys_clk <= 1'b1;
    wr(`CSPS_A_PLL, 8'h08);
    rd(`CSPS_A_PLL);
    chk(rv, 8'h0a, "forced enable");
    pll_is_sys_clk <= 1'b0;
    pll_lock_in <= 1'b1;
    rd(`CSPS_A_PLL);
    chk(rv[0], 1'b1, "lock flag");
    wr(`CSPS_A_PLL, 8'h08);
    wr(`CSPS_A_MCU, 8'h04);
    rd(`CSPS_A_MCU);
    chk(rc_1mhz_sel, 1'b1, "rc 1mhz");
    chk(pll_run, 1'b0, "pll stopped");
    rc_osc_enabled <= 1'b0;
    idle(2);
    #1 chk(rc_1mhz_sel, 1'b0, "rc cleared");
    wr(`CSPS_A_MCU, 8'h04);
    idle(1);
    #1 chk(rc_1mhz_sel, 1'b0, "rc write ignored");
    rc_osc_enabled <= 1'b1;
    $display("pll and rc done");
    foreach (good[i])
    begin
      wr(`CSPS_A_SEL, {4'h5, good[i] + 4'h8});
      issue(`CSPS_CCE_ONLY, 0, -1, good[i], 1'b1);
      chk(cmd_code, good[i], "code");
      chk(cmd_source, good[i] + 4'h8, "source");
      chk(cmd_startup, 2'h1, "startup");
      chk(clock_out_en, good[i] == 4'h7, "clock out");
    end
    rd(`CSPS_A_CMD);
    chk(rv[4], 1'b0, "ready cleared");
    clk_avail_in <= 1'b1;
    n = 0;
    rd(`CSPS_A_CMD);
    while (rv[4] !== 1'b1 && n < 20)
    begin
      rd(`CSPS_A_CMD);
      n++;
    end
    chk(rv[4], 1'b1, "ready set");
    if (n >= 20)
      results();
    clk_avail_in <= 1'b0;
    issue(`CSPS_CCE_ONLY, 0, -1, `CSPS_CMD_AVAIL, 1'b1);
    rd(`CSPS_A_CMD);
    chk(rv[4], 1'b0, "ready on request");
    issue(`CSPS_CCE_ONLY, 0, -1, `CSPS_CMD_RECOVER, 1'b1);
    rd(`CSPS_A_SEL);
    chk(rv, 8'h53, "recover");
    foreach (none[i])
      issue(`CSPS_CCE_ONLY, 0, -1, none[i], 1'b0);
    issue(`CSPS_CCE_ONLY, 2, -1, 4'h2, 1'b1);
    issue(`CSPS_CCE_ONLY, 4, -1, 4'h2, 1'b0);
    issue(`CSPS_CCE_ONLY, 1, 2, 4'h2, 1'b0);
    issue(8'h81, 0, -1, 4'h2, 1'b0);
    $display("commands done");
    nap(4'h0, 6'h3f);
    ext_xtal_selected <= 1'b0;
    nap(4'hd, 6'h3f);
    ext_xtal_selected <= 1'b1;
    nap(4'h1, 6'h0f);
    wake(4);
    nap(4'h3, 6'h07);
    wake(4);
    nap(4'h5, 6'h00);
    wake(20);
    nap(4'hd, 6'h01);
    wake(6);
    nap(4'h5, 6'h00);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    idle(2);
    #1 chk({cpu_clk_en, io_clk_en, main_src_en}, 3'h7, "reset wake");
    rd(`CSPS_A_SEL);
    chk(rv, 8'h69, "fuse reload");
    $display("sleep done");
    results();
  end
endmodule // tb_csps_clock_ctrl
`default_nettype wire
